// *** rtl/pspr_regs.svh ***
`ifndef PSPR_REGS_SVH
`define PSPR_REGS_SVH
// parallel port mode codes
`define PSPR_PM_DATA_EXTERNAL_MEMORY_INTERFACE 2'h0
`define PSPR_PM_FULL_EXTERNAL_MEMORY_INTERFACE 2'h1
`define PSPR_PM_HOST_FLAT 2'h2
`define PSPR_PM_HOST_MUX  2'h3
// serial port mode codes
`define PSPR_SM_BSP       2'h0
`define PSPR_SM_CARD      2'h1
`define PSPR_SM_RSVD_A    2'h2
`define PSPR_SM_RSVD_B    2'h3
// widths
`define PSPR_ADDR_PINS    16
`define PSPR_HOST_AW      14
`define PSPR_GPIO_W       22
// control pin positions
`define PSPR_C_HOST_INTERRUPT_OUT       1
`define PSPR_C_ASYNC_READY_INPUT       3
`define PSPR_C_HOST_READY_OUT       3
// reset value of every enable: pin released
`define PSPR_OE_RESET     1'h1
`endif

// *** rtl/pspr_pkg.sv ***
package pspr_pkg;
  `include "pspr_regs.svh"

  typedef enum logic [1:0] {
    PSPR_DATA_EXTERNAL_MEMORY_INTERFACE = 2'b00,
    PSPR_FULL_EXTERNAL_MEMORY_INTERFACE = 2'b01,
    PSPR_HOST_FLAT = 2'b10,
    PSPR_HOST_MUX  = 2'b11
  } pspr_par_mode_t;

  typedef enum logic [1:0] {
    PSPR_SER_BSP    = 2'b00,
    PSPR_SER_CARD   = 2'b01,
    PSPR_SER_RSVD_A = 2'b10,
    PSPR_SER_RSVD_B = 2'b11
  } pspr_ser_mode_t;

  typedef struct packed {
    logic [15:0] a_out;
    logic [15:0] a_oe_n;
    logic [4:0]  a_hi;
    logic        a0x;
    logic [15:0] d_out;
    logic [15:0] d_oe_n;
    logic [14:0] c_out;
    logic [14:0] c_oe_n;
    logic [11:0] s_out;
    logic [11:0] s_oe_n;
    logic [15:0] external_memory_interface_din;
    logic        external_memory_interface_rdy;
    logic [13:0] host_addr;
    logic [15:0] host_din;
    logic [7:0]  host_ctl;
    logic        host_ds2;
    logic [21:0] gpio_in;
    logic [11:0] bsp_in;
    logic [11:0] card_in;
  } pspr_state_t;
endpackage : pspr_pkg

// *** rtl/pspr_serial_mux.sv ***
`timescale 1ns/100ps
// one six-pin serial port; bsp vectors ordered by pin, card vectors by
// function: 0 cmd, 1 clk, 2 dat0, 3 dat1, 4 dat2, 5 dat3
module pspr_serial_mux
  import pspr_pkg::*;
(
  // mode
  input  wire logic [1:0] mode,
  // pins
  input  wire logic [5:0] pin_in,
  output logic      [5:0] pin_out,
  output logic      [5:0] pin_oe_n,
  // buffered serial port side
  input  wire logic [5:0] bsp_out,
  input  wire logic [5:0] bsp_oe_n,
  output logic      [5:0] bsp_in,
  // card port side
  input  wire logic [5:0] card_out,
  input  wire logic [5:0] card_oe_n,
  output logic      [5:0] card_in
);
  function automatic logic [2:0] card_fn(input int pin);
    case (pin)
      0: card_fn = 3'h0;
      1: card_fn = 3'h3;
      2: card_fn = 3'h4;
      3: card_fn = 3'h1;
      4: card_fn = 3'h2;
      default: card_fn = 3'h5;
    endcase
  endfunction : card_fn

  always_comb begin
    pin_out  = '0;
    pin_oe_n = '1;
    bsp_in   = '0;
    card_in  = '0;
    case (pspr_ser_mode_t'(mode))
      PSPR_SER_BSP: begin
        pin_out  = bsp_out;
        pin_oe_n = bsp_oe_n;
        bsp_in   = pin_in;
      end
      PSPR_SER_CARD: begin
        for (int i = 0; i < 6; i++) begin
          pin_out[i]           = card_out[card_fn(i)];
          pin_oe_n[i]          = card_oe_n[card_fn(i)];
          card_in[card_fn(i)]  = pin_in[i];
        end
      end
      // reserved codes release the pins and feed nobody
      default: pin_oe_n = '1;
    endcase
  end
endmodule : pspr_serial_mux

// *** rtl/pspr_gpio_bank.sv ***
`timescale 1ns/100ps
`include "pspr_regs.svh"
// pins on loan to gpio; a pin drives only while loaned and set to output
module pspr_gpio_bank
  import pspr_pkg::*;
#(
  parameter int W = `PSPR_GPIO_W
)
(
  // loan mask from the router
  input  wire logic [W-1:0] avail,
  // software side
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] dout,
  output logic      [W-1:0] din,
  // pin side
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_n
);
  always_comb begin
    pin_oe_n = ~(avail & dir);
    pin_out  = dout & avail;
    din      = pin_in & avail;
  end
endmodule : pspr_gpio_bank

// *** rtl/pspr_router.sv ***
`timescale 1ns/100ps
`include "pspr_regs.svh"
// How it works
// - two-bit field picks four parallel assignments
// - data memory mode: data, control; address is gpio
// - full memory mode: address (A0 gpio on larger package), data, control
// - flat host mode: 14 address; six controls gpio
// - muxed host: C7 select, C10 strobe, four gpio
// - muxed host: every address pin is gpio
// - upper address pins always memory address
// - 16-bit async rw, 8-bit read, SDRAM
// - 16-bit memories hold address bit zero low
// - larger package: extra bit-zero pin memory-only
// - async reaches 16K/2M bytes; SDRAM 16M
// - serial mode 00 routes buffered serial port
// - serial mode 01 routes memory-card port
// - serial pin order per function in each mode
// - second serial port independent, same order
// - serial codes 10 and 11 reserved
module pspr_router
  import pspr_pkg::*;
#(
  parameter bit BGA_PKG = 1'b1
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // mode fields
  input  wire logic [1:0]  par_mode,
  input  wire logic [1:0]  sp1_mode,
  input  wire logic [1:0]  sp2_mode,
  // address pins
  input  wire logic [15:0] addr_pin_in,
  output logic      [15:0] addr_pin_out,
  output logic      [15:0] addr_pin_oe_n,
  output logic      [4:0]  addr_hi_pin_out,
  output logic             addr_alt0_pin_out,
  // data pins
  input  wire logic [15:0] data_pin_in,
  output logic      [15:0] data_pin_out,
  output logic      [15:0] data_pin_oe_n,
  // control pins C0..C14
  input  wire logic [14:0] ctrl_pin_in,
  output logic      [14:0] ctrl_pin_out,
  output logic      [14:0] ctrl_pin_oe_n,
  // external memory interface
  input  wire logic [20:0] external_memory_interface_addr,
  input  wire logic        external_memory_interface_mem_8bit,
  input  wire logic        external_memory_interface_async_cycle,
  input  wire logic [15:0] external_memory_interface_dout,
  input  wire logic        external_memory_interface_dout_en,
  output logic      [15:0] external_memory_interface_din,
  input  wire logic        external_memory_interface_async_read_strobe_n,
  input  wire logic        async_output_enable_n,
  input  wire logic        async_write_strobe_n,
  output logic             async_ready_input,
  input  wire logic [3:0]  chip_select_n,
  input  wire logic [1:0]  byte_lane_n,
  input  wire logic        sdram_row_strobe_n,
  input  wire logic        sdram_column_strobe_n,
  input  wire logic        sdram_write_strobe_n,
  input  wire logic        sdram_precharge_bit,
  input  wire logic        memory_clock_out,
  // host port
  output logic      [13:0] host_addr,
  output logic      [15:0] host_din,
  input  wire logic [15:0] host_dout,
  input  wire logic        host_dout_en,
  input  wire logic        host_interrupt_out_n,
  input  wire logic        host_ready_out,
  output logic             host_direction,
  output logic             host_control_select_0,
  output logic             host_control_select_1,
  output logic             host_byte_lane_0_n,
  output logic             host_byte_lane_1_n,
  output logic             host_addr_strobe_n,
  output logic             host_chip_select_n,
  output logic             host_data_strobe_1_n,
  output logic             host_data_strobe_2_n,
  // gpio: [15:0] address pins, [21:16] C0,C4,C5,C7,C10,C13
  input  wire logic [21:0] gpio_dir,
  input  wire logic [21:0] gpio_dout,
  output logic      [21:0] gpio_din,
  // serial ports, port 1 low six bits, port 2 high six bits
  input  wire logic [11:0] ser_pin_in,
  output logic      [11:0] ser_pin_out,
  output logic      [11:0] ser_pin_oe_n,
  input  wire logic [11:0] bsp_out,
  input  wire logic [11:0] bsp_oe_n,
  output logic      [11:0] bsp_in,
  input  wire logic [11:0] card_out,
  input  wire logic [11:0] card_oe_n,
  output logic      [11:0] card_in
);
  if (BGA_PKG !== 1'b0 && BGA_PKG !== 1'b1) begin : g_bad_pkg
    $error("BGA_PKG must be 0 or 1");
  end

  pspr_state_t state_reg;
  pspr_state_t state_next;

  logic [21:0] gpio_avail;
  logic [21:0] gpio_pin_in;
  logic [21:0] gpio_pin_out;
  logic [21:0] gpio_pin_oe_n;
  logic [21:0] gpio_din_c;
  logic [11:0] ser_out_c;
  logic [11:0] ser_oe_n_c;
  logic [11:0] bsp_in_c;
  logic [11:0] card_in_c;

  // control pin that carries gpio bit 16+k
  function automatic int ctrl_of(input int k);
    case (k)
      0: ctrl_of = 0;
      1: ctrl_of = 4;
      2: ctrl_of = 5;
      3: ctrl_of = 7;
      4: ctrl_of = 10;
      default: ctrl_of = 13;
    endcase
  endfunction : ctrl_of

  // address pins that exist on this package
  function automatic logic addr_exists(input int i);
    addr_exists = (i < `PSPR_HOST_AW) || BGA_PKG;
  endfunction : addr_exists

  logic        mode_external_memory_interface;
  logic        mode_full;
  logic        mode_host;
  logic        mode_mux;
  logic        addr_bit0;
  logic        write_n;
  logic [14:0] external_memory_interface_c;

  always_comb begin
    mode_external_memory_interface = ~par_mode[1];
    mode_full = pspr_par_mode_t'(par_mode) == PSPR_FULL_EXTERNAL_MEMORY_INTERFACE;
    mode_host = par_mode[1];
    mode_mux  = pspr_par_mode_t'(par_mode) == PSPR_HOST_MUX;
    // byte addressing only for 8-bit async parts
    addr_bit0 = external_memory_interface_addr[0] & external_memory_interface_mem_8bit & external_memory_interface_async_cycle;
    // 8-bit async memory is read-only: no write strobe
    write_n   = async_write_strobe_n | (external_memory_interface_mem_8bit & external_memory_interface_async_cycle);
    external_memory_interface_c = {memory_clock_out, sdram_precharge_bit, sdram_write_strobe_n,
              sdram_column_strobe_n, sdram_row_strobe_n, byte_lane_n,
              chip_select_n, 1'b1, write_n, async_output_enable_n,
              external_memory_interface_async_read_strobe_n};
  end

  always_comb begin
    gpio_avail = '0;
    for (int i = 0; i < `PSPR_ADDR_PINS; i++) begin
      // data memory and muxed host modes lend every address pin
      if (addr_exists(i) && (pspr_par_mode_t'(par_mode) == PSPR_DATA_EXTERNAL_MEMORY_INTERFACE || mode_mux))
        gpio_avail[i] = 1'b1;
    end
    // on the larger package pin A0 is not a memory address pin
    if (mode_full && BGA_PKG)
      gpio_avail[0] = 1'b1;
    if (mode_host) begin
      gpio_avail[16] = 1'b1;
      gpio_avail[17] = 1'b1;
      gpio_avail[18] = 1'b1;
      gpio_avail[21] = 1'b1;
      gpio_avail[19] = ~mode_mux;
      gpio_avail[20] = ~mode_mux;
    end
    gpio_pin_in = {ctrl_pin_in[13], ctrl_pin_in[10], ctrl_pin_in[7],
                   ctrl_pin_in[5], ctrl_pin_in[4], ctrl_pin_in[0], addr_pin_in};
  end

  pspr_gpio_bank #(
    .W        (22)
  ) u_gpio (
    .avail    (gpio_avail),
    .dir      (gpio_dir),
    .dout     (gpio_dout),
    .din      (gpio_din_c),
    .pin_in   (gpio_pin_in),
    .pin_out  (gpio_pin_out),
    .pin_oe_n (gpio_pin_oe_n)
  );

  pspr_serial_mux u_ser1 (
    .mode      (sp1_mode),
    .pin_in    (ser_pin_in[5:0]),
    .pin_out   (ser_out_c[5:0]),
    .pin_oe_n  (ser_oe_n_c[5:0]),
    .bsp_out   (bsp_out[5:0]),
    .bsp_oe_n  (bsp_oe_n[5:0]),
    .bsp_in    (bsp_in_c[5:0]),
    .card_out  (card_out[5:0]),
    .card_oe_n (card_oe_n[5:0]),
    .card_in   (card_in_c[5:0])
  );

  // separate field, same pin order
  pspr_serial_mux u_ser2 (
    .mode      (sp2_mode),
    .pin_in    (ser_pin_in[11:6]),
    .pin_out   (ser_out_c[11:6]),
    .pin_oe_n  (ser_oe_n_c[11:6]),
    .bsp_out   (bsp_out[11:6]),
    .bsp_oe_n  (bsp_oe_n[11:6]),
    .bsp_in    (bsp_in_c[11:6]),
    .card_out  (card_out[11:6]),
    .card_oe_n (card_oe_n[11:6]),
    .card_in   (card_in_c[11:6])
  );

  always_comb begin
    state_next        = '0;
    state_next.a_oe_n = '1;
    state_next.d_oe_n = '1;
    state_next.c_oe_n = '1;
    // strobe 2 idles high outside host modes
    state_next.host_ds2 = mode_host ? ctrl_pin_in[14] : 1'b1;
    // upper address and extra bit-zero pin belong to memory only
    state_next.a_hi   = BGA_PKG ? external_memory_interface_addr[20:16] : 5'h00;
    state_next.a0x    = BGA_PKG & mode_full & addr_bit0;
    for (int i = 0; i < `PSPR_ADDR_PINS; i++) begin
      if (gpio_avail[i]) begin
        state_next.a_out[i]  = gpio_pin_out[i];
        state_next.a_oe_n[i] = gpio_pin_oe_n[i];
      end else if (mode_full && addr_exists(i)) begin
        state_next.a_out[i]  = (i == 0) ? addr_bit0 : external_memory_interface_addr[i];
        state_next.a_oe_n[i] = 1'b0;
      end
    end
    if (mode_external_memory_interface) begin
      state_next.d_out     = external_memory_interface_dout;
      state_next.d_oe_n    = {16{~external_memory_interface_dout_en}};
      state_next.external_memory_interface_din  = data_pin_in;
      state_next.c_out     = external_memory_interface_c;
      state_next.c_oe_n    = 15'h0000;
      state_next.c_oe_n[`PSPR_C_ASYNC_READY_INPUT] = 1'b1;
      state_next.external_memory_interface_rdy  = ctrl_pin_in[`PSPR_C_ASYNC_READY_INPUT];
    end else begin
      state_next.d_out     = host_dout;
      state_next.d_oe_n    = {16{~host_dout_en}};
      state_next.host_din  = data_pin_in;
      state_next.c_out[`PSPR_C_HOST_INTERRUPT_OUT]  = host_interrupt_out_n;
      state_next.c_oe_n[`PSPR_C_HOST_INTERRUPT_OUT] = 1'b0;
      state_next.c_out[`PSPR_C_HOST_READY_OUT]  = host_ready_out;
      state_next.c_oe_n[`PSPR_C_HOST_READY_OUT] = 1'b0;
      if (!mode_mux)
        state_next.host_addr = addr_pin_in[13:0];
      // order: dir, sel0, sel1, lane0, lane1, addr strobe, cs, ds1
      state_next.host_ctl = {ctrl_pin_in[12], ctrl_pin_in[11],
                             mode_mux ? ctrl_pin_in[10] : 1'b1,
                             ctrl_pin_in[9], ctrl_pin_in[8],
                             mode_mux ? ctrl_pin_in[7] : 1'b0,
                             ctrl_pin_in[6], ctrl_pin_in[2]};
      for (int k = 0; k < 6; k++) begin
        if (gpio_avail[16+k]) begin
          state_next.c_out[ctrl_of(k)]  = gpio_pin_out[16+k];
          state_next.c_oe_n[ctrl_of(k)] = gpio_pin_oe_n[16+k];
        end
      end
    end
    state_next.gpio_in = gpio_din_c;
    state_next.s_out   = ser_out_c;
    state_next.s_oe_n  = ser_oe_n_c;
    state_next.bsp_in  = bsp_in_c;
    state_next.card_in = card_in_c;
  end

  // registered so every pin leaves a flip-flop: one cycle behind fields
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg        <= '0;
      state_reg.a_oe_n <= '1;
      state_reg.d_oe_n <= '1;
      state_reg.c_oe_n <= '1;
      state_reg.s_oe_n <= '1;
      state_reg.host_ds2 <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    addr_pin_out          = state_reg.a_out;
    addr_pin_oe_n         = state_reg.a_oe_n;
    addr_hi_pin_out       = state_reg.a_hi;
    addr_alt0_pin_out     = state_reg.a0x;
    data_pin_out          = state_reg.d_out;
    data_pin_oe_n         = state_reg.d_oe_n;
    ctrl_pin_out          = state_reg.c_out;
    ctrl_pin_oe_n         = state_reg.c_oe_n;
    external_memory_interface_din              = state_reg.external_memory_interface_din;
    async_ready_input     = state_reg.external_memory_interface_rdy;
    host_addr             = state_reg.host_addr;
    host_din              = state_reg.host_din;
    host_direction        = state_reg.host_ctl[0];
    host_control_select_0 = state_reg.host_ctl[1];
    host_control_select_1 = state_reg.host_ctl[2];
    host_byte_lane_0_n    = state_reg.host_ctl[3];
    host_byte_lane_1_n    = state_reg.host_ctl[4];
    host_addr_strobe_n    = state_reg.host_ctl[5];
    host_chip_select_n    = state_reg.host_ctl[6];
    host_data_strobe_1_n  = state_reg.host_ctl[7];
    host_data_strobe_2_n  = state_reg.host_ds2;
    gpio_din              = state_reg.gpio_in;
    ser_pin_out           = state_reg.s_out;
    ser_pin_oe_n          = state_reg.s_oe_n;
    bsp_in                = state_reg.bsp_in;
    card_in               = state_reg.card_in;
  end
endmodule : pspr_router

// *** testbench/pspr_router_asserts.sv ***
`timescale 1ns/100ps
module pspr_router_asserts
  import pspr_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // mode fields
  input wire logic [1:0]  par_mode,
  input wire logic [1:0]  sp1_mode,
  input wire logic [1:0]  sp2_mode,
  // parallel side
  input wire logic [20:0] external_memory_interface_addr,
  input wire logic        external_memory_interface_mem_8bit,
  input wire logic [15:0] addr_pin_in,
  input wire logic [15:0] addr_pin_out,
  input wire logic [15:0] addr_pin_oe_n,
  input wire logic [4:0]  addr_hi_pin_out,
  input wire logic        addr_alt0_pin_out,
  input wire logic [14:0] ctrl_pin_in,
  input wire logic [14:0] ctrl_pin_oe_n,
  input wire logic [13:0] host_addr,
  input wire logic        host_control_select_1,
  input wire logic [21:0] gpio_dir,
  // serial side
  input wire logic [11:0] ser_pin_out,
  input wire logic [11:0] ser_pin_oe_n,
  input wire logic [11:0] bsp_out,
  input wire logic [11:0] bsp_oe_n,
  input wire logic [11:0] bsp_in,
  input wire logic [11:0] card_out,
  input wire logic [11:0] card_in
);
  logic       live_reg;
  logic [5:0] card_pin_reg;

  // first edge after reset still shows reset values, so $past checks wait one
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      live_reg     <= 1'h0;
      card_pin_reg <= 6'h0;
    end else begin
      live_reg     <= 1'h1;
      card_pin_reg <= {card_out[5], card_out[2], card_out[1], card_out[4], card_out[3], card_out[0]};
    end
  end

  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  chk_upper_addr: assert property (live_reg |-> addr_hi_pin_out == $past(external_memory_interface_addr[20:16]))
    else $error("upper address pins wrong");
  chk_full_addr: assert property (par_mode == 2'h1 |=> addr_pin_oe_n[15:1] == 15'h0 &&
    addr_pin_out[15:1] == $past(external_memory_interface_addr[15:1]))
    else $error("full memory address wrong");
  chk_flat_host: assert property (par_mode == 2'h2 |=> addr_pin_oe_n == 16'hFFFF &&
    host_addr == $past(addr_pin_in[13:0]))
    else $error("flat host address wrong");
  chk_data_gpio: assert property (par_mode == 2'h0 |=> addr_pin_oe_n == ~$past(gpio_dir[15:0]))
    else $error("data mode address pins wrong");
  chk_mux_host: assert property (par_mode == 2'h3 |=> addr_pin_oe_n == ~$past(gpio_dir[15:0]) &&
    host_control_select_1 == $past(ctrl_pin_in[7]) && ctrl_pin_oe_n[10])
    else $error("muxed host pins wrong");
  chk_narrow_a0: assert property (live_reg && !$past(external_memory_interface_mem_8bit) |-> !addr_alt0_pin_out)
    else $error("bit zero not held low");
  chk_card_order: assert property (sp1_mode == 2'h1 |=> ser_pin_out[5:0] == card_pin_reg)
    else $error("card pin order wrong");
  chk_bsp_port2: assert property (sp2_mode == 2'h0 |=> ser_pin_out[11:6] == $past(bsp_out[11:6]) &&
    ser_pin_oe_n[11:6] == $past(bsp_oe_n[11:6]))
    else $error("port two serial pins wrong");
  chk_rsvd_release: assert property (sp1_mode[1] |=> ser_pin_oe_n[5:0] == 6'h3F &&
    bsp_in[5:0] == 6'h0 && card_in[5:0] == 6'h0)
    else $error("reserved serial mode not released");

  cov_host_swap: cover property (par_mode == 2'h3 ##1 par_mode == 2'h2);
  cov_both_cards: cover property (sp1_mode == 2'h1 && sp2_mode == 2'h1);
  cov_narrow_full: cover property (par_mode == 2'h1 && external_memory_interface_mem_8bit);
endmodule : pspr_router_asserts

// *** testbench/pspr_far_side.sv ***
`timescale 1ns/100ps
// far devices drive only released lines; slow ones present a cycle late
module pspr_far_side
  import pspr_pkg::*;
(
  // clock and pace
  input  wire logic        core_clk,
  input  wire logic        slow,
  // router pins as {serial, control, data, address}
  input  wire logic [58:0] pin_out,
  input  wire logic [58:0] pin_oe_n,
  // far values, fresh every cycle so a released line never keeps old data
  input  wire logic [58:0] far_drive,
  output logic      [58:0] pin_in
);
  logic [58:0] late_reg;
  logic [58:0] far_now;

  always_ff @(posedge core_clk) begin
    late_reg <= far_drive;
  end
  assign far_now = slow ? late_reg : far_drive;
  assign pin_in  = (pin_out & ~pin_oe_n) | (far_now & pin_oe_n);
endmodule : pspr_far_side

// *** testbench/pspr_router_tb.sv ***
`timescale 1ns/100ps
`define PSPR_CHK(nm, ex, sn) \
  begin \
    compares++; \
    if ((sn) !== (ex)) begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", nm, ex, sn); \
    end \
  end
module pspr_router_tb;
  typedef struct packed {
    logic [4:0]  hi;
    logic        alt0;
    logic        hav;
    logic [13:0] ha;
    logic [15:0] async_output_enable;
    logic [11:0] sout;
    logic [11:0] soe;
    logic [14:0] coe;
    logic        c2;
    logic        doe;
  } pspr_exp_t;

  logic         core_clk    = 1'h0;
  logic         reset       = 1'h1;
  logic         slow        = 1'h0;
  logic [255:0] stim        = '0;
  logic [58:0]  far_prev    = '0;
  logic [1:0]   pm_prev     = 2'h0;
  logic [58:0]  p_out;
  logic [58:0]  p_oe_n;
  logic [58:0]  p_in;
  logic [4:0]   hi_out;
  logic         alt0_out;
  logic [13:0]  host_addr;
  pspr_exp_t    e;
  pspr_exp_t    g;
  pspr_exp_t    exq[$];
  int           compares    = 0;
  int           miscompares = 0;

  always #2 core_clk = ~core_clk;

  pspr_router #(.BGA_PKG(1'b1)) uut (
    .core_clk(core_clk), .reset(reset), .par_mode(stim[225:224]), .sp1_mode(stim[227:226]),
    .sp2_mode(stim[229:228]), .addr_pin_in(p_in[15:0]), .addr_pin_out(p_out[15:0]),
    .addr_pin_oe_n(p_oe_n[15:0]), .addr_hi_pin_out(hi_out), .addr_alt0_pin_out(alt0_out),
    .data_pin_in(p_in[31:16]), .data_pin_out(p_out[31:16]), .data_pin_oe_n(p_oe_n[31:16]),
    .ctrl_pin_in(p_in[46:32]), .ctrl_pin_out(p_out[46:32]), .ctrl_pin_oe_n(p_oe_n[46:32]),
    .external_memory_interface_addr(stim[20:0]), .external_memory_interface_mem_8bit(stim[21]), .external_memory_interface_async_cycle(stim[22]),
    .external_memory_interface_dout(stim[38:23]), .external_memory_interface_dout_en(stim[39]), .external_memory_interface_din(),
    .external_memory_interface_async_read_strobe_n(stim[40]), .async_output_enable_n(stim[41]),
    .async_write_strobe_n(stim[42]), .async_ready_input(), .chip_select_n(stim[46:43]),
    .byte_lane_n(stim[48:47]), .sdram_row_strobe_n(stim[49]), .sdram_column_strobe_n(stim[50]),
    .sdram_write_strobe_n(stim[51]), .sdram_precharge_bit(stim[52]), .memory_clock_out(stim[53]),
    .host_addr(host_addr), .host_din(), .host_dout(stim[69:54]), .host_dout_en(stim[70]),
    .host_interrupt_out_n(stim[71]), .host_ready_out(stim[72]), .host_direction(),
    .host_control_select_0(), .host_control_select_1(), .host_byte_lane_0_n(),
    .host_byte_lane_1_n(), .host_addr_strobe_n(), .host_chip_select_n(),
    .host_data_strobe_1_n(), .host_data_strobe_2_n(), .gpio_dir(stim[94:73]),
    .gpio_dout(stim[116:95]), .gpio_din(), .ser_pin_in(p_in[58:47]), .ser_pin_out(p_out[58:47]),
    .ser_pin_oe_n(p_oe_n[58:47]), .bsp_out(stim[128:117]), .bsp_oe_n(stim[140:129]), .bsp_in(),
    .card_out(stim[152:141]), .card_oe_n(stim[164:153]), .card_in()
  );

  pspr_far_side far (
    .core_clk(core_clk), .slow(slow), .pin_out(p_out), .pin_oe_n(p_oe_n),
    .far_drive(stim[223:165]), .pin_in(p_in)
  );

  // v = {card_oe, card_out, bsp_oe, bsp_out} of one port; result {oe_n, out}
  function automatic logic [11:0] ser_exp(input logic [1:0] m, input logic [23:0] v);
    case (m)
      2'h0: ser_exp = v[11:0];
      2'h1: ser_exp = {v[23], v[20], v[19], v[22], v[21], v[18], v[17], v[14], v[13], v[16], v[15], v[12]};
      default: ser_exp = 12'hFC0;
    endcase
  endfunction : ser_exp

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  initial begin
    void'($urandom(32'hCB99));
    repeat (8) @(posedge core_clk);
    #1 reset = 1'h0;
    for (int i = 0; i < 400; i++) begin
      @(posedge core_clk);
      #1;
      far_prev = stim[223:165];
      pm_prev  = stim[225:224];
      for (int j = 0; j < 8; j++) begin
        stim[j*32 +: 32] = $urandom();
      end
      slow   = (i >= 200);
      e.hi   = stim[20:16];
      e.alt0 = (stim[225:224] == 2'h1) & stim[21] & stim[22] & stim[0];
      // pins seen in flat mode are only known once the router has released them
      e.hav  = (stim[225:224] != 2'h2) | (pm_prev == 2'h2);
      e.ha   = (stim[225:224] != 2'h2) ? 14'h0 : slow ? far_prev[13:0] : stim[178:165];
      // 8-bit async cycles never raise a write; host modes leave C2 undriven
      e.c2   = ~stim[225] & (stim[42] | (stim[21] & stim[22]));
      e.doe  = ~(stim[225] ? stim[70] : stim[39]);
      e.coe  = stim[225] ? {1'b1, ~stim[94], 2'h3, ~(stim[93] & ~stim[224]), 2'h3, ~(stim[92] & ~stim[224]),
                            1'b1, ~stim[91], ~stim[90], 3'h2, ~stim[89]} : 15'h0008;
      case (stim[225:224])
        2'h1: e.async_output_enable = {15'h0, ~stim[73]};
        2'h2: e.async_output_enable = 16'hFFFF;
        default: e.async_output_enable = ~stim[88:73];
      endcase
      {e.soe[5:0], e.sout[5:0]} = ser_exp(stim[227:226],
        {stim[158:153], stim[146:141], stim[134:129], stim[122:117]});
      {e.soe[11:6], e.sout[11:6]} = ser_exp(stim[229:228],
        {stim[164:159], stim[152:147], stim[140:135], stim[128:123]});
      exq.push_back(e);
    end
    repeat (3) @(posedge core_clk);
    end_of_test();
  end

  initial begin
    forever begin
      @(posedge core_clk);
      #0.5;
      if (exq.size() > 0) begin
        g = exq.pop_front();
        `PSPR_CHK("upper address", g.hi, hi_out)
        `PSPR_CHK("control enables", g.coe, p_oe_n[46:32])
        `PSPR_CHK("write strobe", g.c2, p_out[34])
        `PSPR_CHK("data enables", {16{g.doe}}, p_oe_n[31:16])
        `PSPR_CHK("extra bit zero", g.alt0, alt0_out)
        `PSPR_CHK("address enables", g.async_output_enable, p_oe_n[15:0])
        if (g.hav) begin
          `PSPR_CHK("host address", g.ha, host_addr)
        end
        `PSPR_CHK("serial enables", g.soe, p_oe_n[58:47])
        `PSPR_CHK("serial outputs", g.sout & ~g.soe, p_out[58:47] & ~g.soe)
      end
    end
  end

  initial begin
    #(1000 * 4);
    miscompares++;
    end_of_test();
  end
endmodule : pspr_router_tb

bind pspr_router pspr_router_asserts chk (
  .core_clk(core_clk), .reset(reset), .par_mode(par_mode), .sp1_mode(sp1_mode), .sp2_mode(sp2_mode),
  .external_memory_interface_addr(external_memory_interface_addr), .external_memory_interface_mem_8bit(external_memory_interface_mem_8bit), .addr_pin_in(addr_pin_in),
  .addr_pin_out(addr_pin_out), .addr_pin_oe_n(addr_pin_oe_n), .addr_hi_pin_out(addr_hi_pin_out),
  .addr_alt0_pin_out(addr_alt0_pin_out), .ctrl_pin_in(ctrl_pin_in), .ctrl_pin_oe_n(ctrl_pin_oe_n),
  .host_addr(host_addr), .host_control_select_1(host_control_select_1), .gpio_dir(gpio_dir),
  .ser_pin_out(ser_pin_out), .ser_pin_oe_n(ser_pin_oe_n), .bsp_out(bsp_out), .bsp_oe_n(bsp_oe_n),
  .bsp_in(bsp_in), .card_out(card_out), .card_in(card_in)
);
